// ### verilog/rly_mode_ctrl.sv
// Mode control and channel source control of the eight-channel relay switch
//
// Functional notes
// - Power-on reset restores every register default and enters idle with all channels off.
// - A low reset pin forces register defaults and the low-power standby state.
// - A high fail-safe request enters limp-home and clears the registers.
// - In limp-home, control ports one to four drive channels one to four directly.
// - In limp-home, channels five to eight are held off.
// - In limp-home, bus writes change neither channels nor configuration.
// - The fail-safe request wins over a low reset pin.
// - A fail-safe request during standby wakes the device into limp-home.
// - Leaving limp-home resets registers, then goes to standby or idle by the reset pin.
// - The first read after limp-home carries the transmission error flag.
// - A written source select picks which control port, if any, drives a channel.
// - Without pin control a channel follows its serial on/off command bit.
// - Under pin control a high port turns the channel on, a low one off.
// - A floating control port reads low and so switches its channels off.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "rly_consts.svh"
module rly_mode_ctrl
  import rly_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire rly_apb_req_t apb_in,
  output logic      [31:0]  prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  input  wire logic         reset_pin_n_in,
  input  wire logic         fail_safe_request_in,
  input  wire logic [3:0]   external_control_ports_in,
  output logic      [7:0]   low_side_switches_out,
  output rly_mode_t         mode_out,
  output logic              irq_out
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [5:0]  pin_meta;
  logic [5:0]  pin_sync;
  logic        fs_req;
  logic        rst_pin_n;
  logic [3:0]  ports;
  rly_mode_t   mode;
  rly_mode_t   next_mode;
  logic [7:0]  chan_on;
  logic [23:0] src_sel;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [2:0]  irq_event;
  logic        transmission_error_flag;
  logic        setup;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic        regs_live;
  logic [7:0]  next_switch;
  logic [31:0] next_rdata;
  logic        next_err;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // ports settle low at reset, like an open pin
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {~reset_pin_n_in, fail_safe_request_in, external_control_ports_in};
      pin_sync <= pin_meta;
    end
  end

  // Reset pin held inverted so that all sync flops clear to the idle level
  assign rst_pin_n = ~pin_sync[5];
  assign fs_req    = pin_sync[4];
  assign ports     = pin_sync[3:0];

  // ------------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------------
  function automatic rly_mode_t pick_mode(input logic fs, input logic rpin_n);
    rly_mode_t m;
    // limp first, then standby, then normal
    if (fs) begin
      m = RLY_LIMP;
    end else if (!rpin_n) begin
      m = RLY_STANDBY;
    end else begin
      m = RLY_NORMAL;
    end
    return m;
  endfunction : pick_mode

  assign next_mode = pick_mode(fs_req, rst_pin_n);

  // power-on lands in normal mode, idle
  // limp exit picks standby or idle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= RLY_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  assign regs_live = (mode == RLY_NORMAL) && (next_mode == RLY_NORMAL);

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  // One wait-free access: answer is prepared in setup, shown in access
  assign setup   = apb_in.psel && !apb_in.penable;
  assign done    = apb_in.psel && apb_in.penable && pready_out;
  assign wr_done = done && apb_in.pwrite;
  assign rd_done = done && !apb_in.pwrite;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (apb_in.paddr)
      `RLY_OFF_CHAN_ON:  next_rdata[7:0]  = chan_on;
      `RLY_OFF_SRC_SEL:  next_rdata[23:0] = src_sel;
      `RLY_OFF_STATUS:   next_rdata[10:0] = {mode, low_side_switches_out};
      `RLY_OFF_IRQ_STAT: next_rdata[2:0]  = irq_stat;
      `RLY_OFF_IRQ_MASK: next_rdata[2:0]  = irq_mask;
      default:           next_err         = 1'b1;
    endcase
    // error flag rides on read data
    next_rdata[`RLY_TER_BIT] = transmission_error_flag;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && next_err;
      if (setup && !apb_in.pwrite) begin
        prdata_out <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  // defaults held while in standby
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_on  <= `RLY_RST_CHAN_ON;
      src_sel  <= `RLY_RST_SRC_SEL;
      irq_mask <= `RLY_RST_IRQ_MASK;
    end else if (!regs_live) begin
      chan_on  <= `RLY_RST_CHAN_ON;
      src_sel  <= `RLY_RST_SRC_SEL;
      irq_mask <= `RLY_RST_IRQ_MASK;
    end else if (wr_done) begin
      if (apb_in.paddr == `RLY_OFF_CHAN_ON) begin
        chan_on <= apb_in.pwdata[7:0];
      end
      if (apb_in.paddr == `RLY_OFF_SRC_SEL) begin
        src_sel <= apb_in.pwdata[23:0];
      end
      if (apb_in.paddr == `RLY_OFF_IRQ_MASK) begin
        irq_mask <= apb_in.pwdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmission error flag
  // ------------------------------------------------------------------
  // set on limp exit, set wins over read clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      transmission_error_flag <= 1'b0;
    end else if (mode == RLY_LIMP && next_mode != RLY_LIMP) begin
      transmission_error_flag <= 1'b1;
    end else if (rd_done && prdata_out[`RLY_TER_BIT]) begin
      // Only a read that actually carried the flag may clear it
      transmission_error_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  // Sticky events kept through limp so software can see why it happened
  assign irq_event[`RLY_IRQ_LIMP_IN]  = (mode != RLY_LIMP) && (next_mode == RLY_LIMP);
  assign irq_event[`RLY_IRQ_LIMP_OUT] = (mode == RLY_LIMP) && (next_mode != RLY_LIMP);
  assign irq_event[`RLY_IRQ_STANDBY]  = (mode != RLY_STANDBY) && (next_mode == RLY_STANDBY);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat <= 3'h0;
    end else if (rd_done && apb_in.paddr == `RLY_OFF_IRQ_STAT) begin
      // Events after the setup edge were not reported, so they stay
      irq_stat <= (irq_stat & ~prdata_out[2:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_irq_stat() & irq_mask);
    end
  end

  function automatic logic [2:0] next_irq_stat();
    logic [2:0] s;
    s = irq_stat | irq_event;
    if (rd_done && apb_in.paddr == `RLY_OFF_IRQ_STAT) begin
      s = (irq_stat & ~prdata_out[2:0]) | irq_event;
    end
    return s;
  endfunction : next_irq_stat

  // ------------------------------------------------------------------
  // Channel outputs
  // ------------------------------------------------------------------
  rly_src_mux u_mux (
    .limp_in         (next_mode == RLY_LIMP),
    .cmd_on_in       (chan_on),
    .sel_in          (src_sel),
    .pins_in         (ports),
    .next_switch_out (next_switch)
  );

  // port levels reach channels through the mux
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_side_switches_out <= 8'h00;
      mode_out              <= RLY_NORMAL;
    end else begin
      low_side_switches_out <= (next_mode == RLY_STANDBY) ? 8'h00 :
                               (next_mode == RLY_LIMP) ? next_switch :
                               (regs_live ? next_switch : 8'h00);
      mode_out              <= next_mode;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  chk_limp_priority: assert property (
    fs_req |=> mode == RLY_LIMP)
    else $error("fail-safe request did not select limp mode");

  chk_standby_mode: assert property (
    !fs_req && !rst_pin_n |=> mode == RLY_STANDBY && low_side_switches_out == 8'h00)
    else $error("reset pin low did not give standby with outputs off");

  chk_limp_route: assert property (
    mode_out == RLY_LIMP |-> low_side_switches_out[3:0] == $past(ports))
    else $error("limp routing of ports to channels wrong");

  chk_limp_upper_off: assert property (
    mode_out == RLY_LIMP |-> low_side_switches_out[7:4] == 4'h0)
    else $error("upper channels on in limp mode");

  chk_limp_clears: assert property (
    mode == RLY_LIMP |-> chan_on == `RLY_RST_CHAN_ON && src_sel == `RLY_RST_SRC_SEL)
    else $error("registers not cleared in limp mode");

  chk_limp_no_write: assert property (
    mode == RLY_LIMP ##1 mode == RLY_LIMP |-> $stable(chan_on) && $stable(src_sel))
    else $error("configuration changed during limp mode");

  chk_wake_limp: assert property (
    mode == RLY_STANDBY && fs_req |=> mode == RLY_LIMP && mode_out == RLY_LIMP)
    else $error("standby did not wake into limp mode");

  chk_limp_exit: assert property (
    mode == RLY_LIMP && !fs_req
      |=> mode == ($past(rst_pin_n) ? RLY_NORMAL : RLY_STANDBY) && transmission_error_flag)
    else $error("limp exit mode or flag wrong");

  chk_ter_cleared: assert property (
    transmission_error_flag && $past(transmission_error_flag) && rd_done && !irq_event[`RLY_IRQ_LIMP_OUT]
      |-> prdata_out[`RLY_TER_BIT] ##1 !transmission_error_flag)
    else $error("error flag not reported then cleared");

  chk_serial_cmd: assert property (
    regs_live && next_mode == RLY_NORMAL && src_sel == `RLY_RST_SRC_SEL
      |=> low_side_switches_out == $past(chan_on))
    else $error("serial command bits not followed");

  chk_pin_cmd: assert property (
    regs_live && src_sel[8:6] == 3'h2 |=> low_side_switches_out[2] == $past(ports[1]))
    else $error("pin control of channel three wrong");

  chk_mode_order: assert property (
    !fs_req && rst_pin_n |=> mode == RLY_NORMAL)
    else $error("normal mode not selected");

  chk_src_write: assert property (
    wr_done && regs_live && apb_in.paddr == `RLY_OFF_SRC_SEL
      |=> src_sel == $past(apb_in.pwdata[23:0]))
    else $error("source select write lost");
endmodule : rly_mode_ctrl

// ### inc/rly_consts.svh
// Register offsets, field positions, reset values for the relay mode control
`ifndef RLY_CONSTS_SVH
`define RLY_CONSTS_SVH
// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define RLY_OFF_CHAN_ON   8'h00
`define RLY_OFF_SRC_SEL   8'h04
`define RLY_OFF_STATUS    8'h08
`define RLY_OFF_IRQ_STAT  8'h0C
`define RLY_OFF_IRQ_MASK  8'h10
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RLY_RST_CHAN_ON   8'h00
`define RLY_RST_SRC_SEL   24'h00_0000
`define RLY_RST_IRQ_MASK  3'h0
// ------------------------------------------------------------------
// Fields
// ------------------------------------------------------------------
`define RLY_SEL_SERIAL    3'h0
`define RLY_SEL_PIN_MAX   3'h4
`define RLY_TER_BIT       31
`define RLY_IRQ_LIMP_IN   0
`define RLY_IRQ_LIMP_OUT  1
`define RLY_IRQ_STANDBY   2
`endif

// ### inc/rly_pkg.sv
// Types shared by the relay mode control design
package rly_pkg;
  typedef enum logic [2:0] {
    RLY_STANDBY = 3'b001,
    RLY_NORMAL  = 3'b010,
    RLY_LIMP    = 3'b100
  } rly_mode_t;

  typedef logic [2:0] rly_sel_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rly_apb_req_t;
endpackage : rly_pkg

// ### verilog/rly_src_mux.sv
// Per-channel source selection between serial command bits and control ports
`timescale 1ns/1ps
`include "rly_consts.svh"
module rly_src_mux
  import rly_pkg::*;
(
  input  wire logic        limp_in,
  input  wire logic [7:0]  cmd_on_in,
  input  wire logic [23:0] sel_in,
  input  wire logic [3:0]  pins_in,
  output logic      [7:0]  next_switch_out
);
  // ------------------------------------------------------------------
  // Source pick
  // ------------------------------------------------------------------
  function automatic logic pick(input rly_sel_t sel, input logic cmd, input logic [3:0] pins);
    logic res;
    res = cmd;
    if (sel != `RLY_SEL_SERIAL && sel <= `RLY_SEL_PIN_MAX) begin
      res = pins[2'(sel - 3'h1)];
    end
    return res;
  endfunction : pick

  always_comb begin
    for (int ch = 0; ch < 8; ch++) begin
      if (limp_in) begin
        next_switch_out[ch] = (ch < 4) ? pins_in[ch[1:0]] : 1'b0;
      end else begin
        next_switch_out[ch] = pick(sel_in[ch*3 +: 3], cmd_on_in[ch], pins_in);
      end
    end
  end
endmodule : rly_src_mux

// ### verification/rly_host.sv
// Host model: APB master and control pin driver for the relay mode control
`timescale 1ns/1ps
module rly_host
  import rly_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output rly_apb_req_t     apb_out,
  output logic             reset_pin_n_out,
  output logic             fail_safe_out,
  output logic [3:0]       ports_out
);
  initial begin
    apb_out         = '0;
    reset_pin_n_out = 1'b1;
    fail_safe_out   = 1'b0;
    ports_out       = 4'h0;
  end
  // one APB read or write transfer, waiting for ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clock_in);
    apb_out <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock_in);
    apb_out.penable <= 1'b1;
    do @(posedge clock_in); while (pready_in !== 1'b1);
    q   = prdata_in;
    err = pslverr_in;
    // Released bus shows inverted values so stale data cannot pass
    apb_out <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
  endtask : xfer
  // open control port modelled by its pull-down level
  task automatic set_pins(input logic rst_n, input logic fs, input logic [3:0] p);
    @(posedge clock_in);
    reset_pin_n_out <= rst_n;
    fail_safe_out   <= fs;
    ports_out       <= p;
  endtask : set_pins
endmodule : rly_host

// ### verification/rly_mode_ctrl_bench.sv
// Self-checking bench for the relay mode control
`timescale 1ns/1ps
`include "rly_consts.svh"
module rly_mode_ctrl_bench
  import rly_pkg::*;
;
  logic         clock_in;
  logic         rst_n_in;
  rly_apb_req_t apb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         reset_pin_n;
  logic         fail_safe;
  logic [3:0]   ports;
  logic [7:0]   switches;
  rly_mode_t    mode;
  logic         irq;
  int           n_mismatch;
  int           cmp_count;

  rly_mode_ctrl u_rly_mode_ctrl (
    .clock_in                  (clock_in),
    .rst_n_in                  (rst_n_in),
    .apb_in                    (apb),
    .prdata_out                (prdata),
    .pready_out                (pready),
    .pslverr_out               (pslverr),
    .reset_pin_n_in            (reset_pin_n),
    .fail_safe_request_in      (fail_safe),
    .external_control_ports_in (ports),
    .low_side_switches_out     (switches),
    .mode_out                  (mode),
    .irq_out                   (irq)
  );
  rly_host u_rly_host (
    .clock_in        (clock_in),
    .prdata_in       (prdata),
    .pready_in       (pready),
    .pslverr_in      (pslverr),
    .apb_out         (apb),
    .reset_pin_n_out (reset_pin_n),
    .fail_safe_out   (fail_safe),
    .ports_out       (ports)
  );
  // ------------------------------------------------------------------
  // Compare and bus helpers
  // ------------------------------------------------------------------
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_pin
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    u_rly_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    cmp_word("read data", exp, q);
    cmp_pin("slave error", 8'h00, {7'h00, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_rly_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  // Pins pass two sync flops and an output register
  task automatic settle();
    repeat (5) @(posedge clock_in);
  endtask : settle
  task automatic cmp_out(input rly_mode_t m, input logic [7:0] sw);
    cmp_pin("mode", {5'h00, m}, {5'h00, mode});
    cmp_pin("switches", sw, switches);
  endtask : cmp_out
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    cmp_out(RLY_NORMAL, 8'h00);
    rd(`RLY_OFF_CHAN_ON, 32'h0000_0000);
    rd(`RLY_OFF_SRC_SEL, 32'h0000_0000);
    rd(`RLY_OFF_IRQ_MASK, 32'h0000_0000);
    rd(`RLY_OFF_STATUS, 32'h0000_0200);
  endtask : t_reset
  task automatic t_source();
    logic [3:0]  p;
    logic [31:0] q;
    logic        e;
    // Channel k uses select code k: covers serial, all four ports, upper codes
    wr(`RLY_OFF_SRC_SEL, 32'h00FA_C688);
    wr(`RLY_OFF_CHAN_ON, 32'h0000_00FF);
    for (int i = 0; i < 4; i++) begin
      p = 4'h5 * i[3:0];
      u_rly_host.set_pins(1'b1, 1'b0, p);
      settle();
      cmp_out(RLY_NORMAL, 8'hE1 | {3'h0, p, 1'b0});
    end
    wr(`RLY_OFF_CHAN_ON, 32'h0000_0000);
    settle();
    cmp_out(RLY_NORMAL, 8'h1E);
    rd(`RLY_OFF_SRC_SEL, 32'h00FA_C688);
    u_rly_host.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
    cmp_pin("unmapped error", 8'h01, {7'h00, e});
    cmp_word("unmapped data", 32'h0000_0000, q);
  endtask : t_source
  task automatic t_limp();
    wr(`RLY_OFF_CHAN_ON, 32'h0000_00FF);
    u_rly_host.set_pins(1'b1, 1'b1, 4'h6);
    settle();
    cmp_out(RLY_LIMP, 8'h06);
    wr(`RLY_OFF_SRC_SEL, 32'h0000_0000);
    wr(`RLY_OFF_CHAN_ON, 32'h0000_00F0);
    u_rly_host.set_pins(1'b1, 1'b1, 4'h9);
    settle();
    cmp_out(RLY_LIMP, 8'h09);
    u_rly_host.set_pins(1'b1, 1'b0, 4'h0);
    settle();
    cmp_out(RLY_NORMAL, 8'h00);
    rd(`RLY_OFF_CHAN_ON, 32'h8000_0000);
    rd(`RLY_OFF_CHAN_ON, 32'h0000_0000);
    rd(`RLY_OFF_SRC_SEL, 32'h0000_0000);
  endtask : t_limp
  task automatic t_irq();
    // Limp entry and exit events are still latched
    wr(`RLY_OFF_IRQ_MASK, 32'h0000_0004);
    settle();
    cmp_pin("irq masked", 8'h00, {7'h00, irq});
    wr(`RLY_OFF_IRQ_MASK, 32'h0000_0003);
    settle();
    cmp_pin("irq raised", 8'h01, {7'h00, irq});
    rd(`RLY_OFF_IRQ_STAT, 32'h0000_0003);
    settle();
    cmp_pin("irq cleared", 8'h00, {7'h00, irq});
    rd(`RLY_OFF_IRQ_STAT, 32'h0000_0000);
  endtask : t_irq
  task automatic t_standby();
    wr(`RLY_OFF_CHAN_ON, 32'h0000_00FF);
    u_rly_host.set_pins(1'b0, 1'b0, 4'hF);
    settle();
    cmp_out(RLY_STANDBY, 8'h00);
    u_rly_host.set_pins(1'b0, 1'b1, 4'h3);
    settle();
    cmp_out(RLY_LIMP, 8'h03);
    u_rly_host.set_pins(1'b0, 1'b0, 4'h3);
    settle();
    cmp_out(RLY_STANDBY, 8'h00);
    u_rly_host.set_pins(1'b1, 1'b0, 4'h0);
    settle();
    cmp_out(RLY_NORMAL, 8'h00);
    rd(`RLY_OFF_IRQ_STAT, 32'h8000_0007);
    rd(`RLY_OFF_CHAN_ON, 32'h0000_0000);
  endtask : t_standby
  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    n_mismatch = 0;
    cmp_count  = 0;
    rst_n_in   = 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_source();
    t_limp();
    t_irq();
    t_standby();
    end_sim();
  end
endmodule : rly_mode_ctrl_bench
